// File: rtl/ara_pkg.sv
/*
 * Constants, types and decode helper of the address-register adder.
 * Assumes a 16-bit address unit with eight auxiliary and four
 * temporary registers, reached by a plain register port.
 */
// Behaviour
// [RQ1] Register form adds signed source register into destination register.
// [RQ2] Immediate form adds unsigned 8-bit program offset into named register.
// [RQ3] Done in one address-phase cycle, never requesting data memory.
// [RQ4] Aux destination with circular enable set gets circular modification.
// [RQ5] Legacy mode with circular modification takes size from low bank only.
// [RQ6] Translated legacy code runs this only with legacy mode bit set.
// [RQ7] Decoder accepts both opcode tails, 0000 and 1000, after leading 0001.
// [RQ8] Runs under single repeat, one update per repeat iteration.
// [RQ9] Without circular modification the sum wraps at 16 bits, no flags.
package ara_pkg;

   // ****************************************************************
   // Widths and sizes
   // ****************************************************************
   localparam int ARA_W = 16;
   localparam int ARA_NUM_AR = 8;
   localparam int ARA_NUM_REGS = 12;
   localparam logic [3:0] ARA_AR_LOW_BANK_LAST = 4'h3;

   // ****************************************************************
   // Opcode fields
   // ****************************************************************
   localparam logic [3:0] ARA_OPC_LEAD = 4'h1;
   localparam logic [2:0] ARA_OPC_MID = 3'h2;
   localparam logic [3:0] ARA_TAIL_RR_A = 4'h0;
   localparam logic [3:0] ARA_TAIL_RR_B = 4'h8;
   localparam logic [3:0] ARA_TAIL_IMM_A = 4'h4;
   localparam logic [3:0] ARA_TAIL_IMM_B = 4'hc;

   // ****************************************************************
   // Register map and reset values
   // ****************************************************************
   localparam logic [5:0] ARA_ADDR_REGS_END = 6'h0c;
   localparam logic [5:0] ARA_ADDR_ST2 = 6'h10;
   localparam logic [5:0] ARA_ADDR_SIZE_LO = 6'h11;
   localparam logic [5:0] ARA_ADDR_SIZE_HI = 6'h12;
   localparam logic [5:0] ARA_ADDR_START_LO = 6'h13;
   localparam logic [5:0] ARA_ADDR_START_HI = 6'h14;
   localparam logic [5:0] ARA_ADDR_COUNT = 6'h15;
   localparam int ARA_ST2_LEGACY_BIT = 8;
   localparam logic [15:0] ARA_RST_VAL = 16'h0000;

   typedef enum logic [1:0] {
      ARA_OP_NONE = 2'b00,
      ARA_OP_REG = 2'b01,
      ARA_OP_IMM = 2'b10
   } ara_op_t;

   // Classify a 24-bit instruction word
   function automatic ara_op_t ara_decode(input logic [23:0] w);
      ara_op_t op;
      op = ARA_OP_NONE;
      if (w[23:20] == ARA_OPC_LEAD && w[19:17] == ARA_OPC_MID) begin
         if (w[3:0] == ARA_TAIL_RR_A || w[3:0] == ARA_TAIL_RR_B) begin
            op = ARA_OP_REG;
         end else if (w[3:0] == ARA_TAIL_IMM_A ||
                      w[3:0] == ARA_TAIL_IMM_B) begin
            op = ARA_OP_IMM;
         end
      end
      return op;
   endfunction

endpackage

// File: rtl/ara_circ_mod.sv
/*
 * Circular-buffer modifier of the address-register adder.
 * Assumes each step is smaller than the buffer; a size of zero
 * leaves the address unmodified.
 */
`timescale 1ns/1ns
module ara_circ_mod
   import ara_pkg::*;
#(
   parameter int W = ARA_W
) (
   // Operands
   input wire logic [W-1:0] sum_i,
   input wire logic [W-1:0] start_i,
   input wire logic [W-1:0] size_i,
   input wire logic enable_i,
   // Result
   output logic [W-1:0] result_o
);

   logic [W:0] offset;

   // Offset of the raw sum from the buffer start, sign in the top bit
   assign offset = {1'b0, sum_i} - {1'b0, start_i};

   // One fold back into the buffer; larger steps would need a divider
   always_comb begin
      result_o = sum_i;
      if (enable_i && size_i != '0) begin
         if (offset[W]) begin
            result_o = sum_i + size_i; // [RQ4]
         end else if (offset[W-1:0] >= size_i) begin
            result_o = sum_i - size_i; // [RQ4]
         end
      end
   end

endmodule

// File: rtl/ara_unit.sv
/*
 * Address-register adder: register-register and immediate forms,
 * with circular modification. Assumes the decoder presents one
 * instruction word per cycle while the pipeline is in address phase,
 * and that a repeat controller re-presents it once per iteration.
 */
`timescale 1ns/1ns
module ara_unit
   import ara_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Register port
   input wire logic [5:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   // Instruction port
   input wire logic instr_valid_i,
   input wire logic [23:0] instr_i,
   output logic done_o,
   output logic illegal_o,
   output logic dmem_req_o
);

   // ****************************************************************
   // State
   // ****************************************************************
   logic [15:0] regs_q [ARA_NUM_REGS];
   logic [15:0] st2_q;
   logic [15:0] size_lo_q;
   logic [15:0] size_hi_q;
   logic [15:0] start_lo_q;
   logic [15:0] start_hi_q;
   logic [15:0] exec_cnt_q;
   logic [15:0] rdata_q;
   logic done_q;
   logic illegal_q;

   // ****************************************************************
   // Decode and operand selection
   // ****************************************************************
   ara_op_t op;
   logic [3:0] src_idx;
   logic [3:0] dst_idx;
   logic regs_ok;
   logic exec;
   logic [15:0] src_val;
   logic [15:0] dst_val;
   logic [15:0] addend;
   logic [15:0] plain_sum;
   logic legacy;
   logic circ_en;
   logic use_low_bank;
   logic [15:0] size_sel;
   logic [15:0] start_sel;
   logic [15:0] result;

   // Both tails of each form are the same operation
   assign op = instr_valid_i ? ara_decode(instr_i) : ARA_OP_NONE; // [RQ7]
   assign src_idx = instr_i[15:12];
   assign dst_idx = instr_i[7:4];
   assign regs_ok = dst_idx < 4'(ARA_NUM_REGS) &&
                    (op != ARA_OP_REG || src_idx < 4'(ARA_NUM_REGS));
   // Every decoded word with mapped register codes executes, so each repeat pass updates once
   assign exec = op != ARA_OP_NONE && regs_ok; // [RQ8]

   // Unmapped codes read zero; exec is low for them, except a source code in the immediate form, where src_val is unused
   assign src_val = src_idx < 4'(ARA_NUM_REGS) ? regs_q[src_idx] : '0;
   assign dst_val = dst_idx < 4'(ARA_NUM_REGS) ? regs_q[dst_idx] : '0;

   // Signed source adds as two's complement, immediate zero-extends
   assign addend = (op == ARA_OP_REG) ? src_val // [RQ1]
                 : {8'h00, instr_i[15:8]}; // [RQ2]
   assign plain_sum = dst_val + addend; // [RQ9]

   // Circular mode only for auxiliary destinations with bit set
   assign legacy = st2_q[ARA_ST2_LEGACY_BIT];
   assign circ_en = dst_idx < 4'(ARA_NUM_AR) &&
                    st2_q[dst_idx[2:0]]; // [RQ4]
   // Legacy mode never looks at the high-bank size register
   assign use_low_bank = legacy || dst_idx <= ARA_AR_LOW_BANK_LAST; // [RQ5]
   assign size_sel = use_low_bank ? size_lo_q : size_hi_q;
   assign start_sel = use_low_bank ? start_lo_q : start_hi_q;

   ara_circ_mod #(
      .W(ARA_W)
   ) u_circ (
      .sum_i(plain_sum),
      .start_i(start_sel),
      .size_i(size_sel),
      .enable_i(circ_en),
      .result_o(result)
   );

   // ****************************************************************
   // Register file: instruction update wins over a port write
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         for (int i = 0; i < ARA_NUM_REGS; i++) begin
            regs_q[i] <= ARA_RST_VAL;
         end
      end else begin
         if (wr_i && addr_i < ARA_ADDR_REGS_END) begin
            regs_q[addr_i[3:0]] <= wdata_i;
         end
         if (exec) begin
            regs_q[dst_idx] <= result; // [RQ1] [RQ2] [RQ4] [RQ9]
         end
      end
   end

   // Control registers written from the port
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st2_q <= ARA_RST_VAL;
         size_lo_q <= ARA_RST_VAL;
         size_hi_q <= ARA_RST_VAL;
         start_lo_q <= ARA_RST_VAL;
         start_hi_q <= ARA_RST_VAL;
      end else if (wr_i) begin
         case (addr_i)
            ARA_ADDR_ST2: st2_q <= wdata_i;
            ARA_ADDR_SIZE_LO: size_lo_q <= wdata_i;
            ARA_ADDR_SIZE_HI: size_hi_q <= wdata_i;
            ARA_ADDR_START_LO: start_lo_q <= wdata_i;
            ARA_ADDR_START_HI: start_hi_q <= wdata_i;
            default: ;
         endcase
      end
   end

   // Iteration counter; wraps, write any value to clear it in a cycle with no execution
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         exec_cnt_q <= ARA_RST_VAL;
      end else if (exec) begin
         exec_cnt_q <= exec_cnt_q + 16'h0001; // [RQ8]
      end else if (wr_i && addr_i == ARA_ADDR_COUNT) begin
         exec_cnt_q <= ARA_RST_VAL;
      end
   end

   // Read data one cycle after the strobe, zero elsewhere
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata_q <= ARA_RST_VAL;
      end else if (rd_i) begin
         if (addr_i < ARA_ADDR_REGS_END) begin
            rdata_q <= regs_q[addr_i[3:0]];
         end else begin
            case (addr_i)
               ARA_ADDR_ST2: rdata_q <= st2_q;
               ARA_ADDR_SIZE_LO: rdata_q <= size_lo_q;
               ARA_ADDR_SIZE_HI: rdata_q <= size_hi_q;
               ARA_ADDR_START_LO: rdata_q <= start_lo_q;
               ARA_ADDR_START_HI: rdata_q <= start_hi_q;
               ARA_ADDR_COUNT: rdata_q <= exec_cnt_q;
               default: rdata_q <= ARA_RST_VAL;
            endcase
         end
      end else begin
         rdata_q <= ARA_RST_VAL;
      end
   end

   // Completion and refusal pulses
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         done_q <= 1'b0;
         illegal_q <= 1'b0;
      end else begin
         done_q <= exec; // [RQ3]
         illegal_q <= op != ARA_OP_NONE && !regs_ok;
      end
   end

   assign rdata_o = rdata_q;
   assign done_o = done_q;
   assign illegal_o = illegal_q;
   // Pure address-phase work: the data bus is never asked for
   assign dmem_req_o = 1'b0; // [RQ3]

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic circ_fits;
   assign circ_fits = circ_en && size_sel != '0 &&
                      16'(dst_val - start_sel) < size_sel &&
                      addend < size_sel;

   AST_RR_SUM: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ1]
      exec && op == ARA_OP_REG && !circ_en |=>
      regs_q[$past(dst_idx)] == $past(plain_sum) && done_o)
      else $error("register form sum not stored");

   AST_IMM_SUM: assert property ( // [RQ2]
      @(posedge clk_i) disable iff (reset_i)
      exec && op == ARA_OP_IMM && !circ_en |->
      addend[15:8] == 8'h00 ##1 regs_q[$past(dst_idx)] == $past(plain_sum))
      else $error("immediate form sum wrong");

   AST_ONE_CYCLE: assert property ( // [RQ3]
      @(posedge clk_i) disable iff (reset_i)
      exec |=> done_o && !dmem_req_o ##1 !done_o || $past(exec))
      else $error("completion not one cycle or memory requested");

   AST_CIRC_RANGE: assert property ( // [RQ4]
      @(posedge clk_i) disable iff (reset_i)
      exec && circ_fits |=>
      16'(regs_q[$past(dst_idx)] - $past(start_sel)) < $past(size_sel))
      else $error("circular result left the buffer");

   AST_LEGACY_SIZE: assert property ( // [RQ5]
      @(posedge clk_i) disable iff (reset_i)
      exec && legacy && circ_en |-> size_sel == size_lo_q)
      else $error("legacy mode used high-bank size");

   AST_BOTH_TAILS: assert property ( // [RQ7]
      @(posedge clk_i) disable iff (reset_i)
      instr_valid_i && regs_ok && instr_i[23:17] == {ARA_OPC_LEAD, ARA_OPC_MID}
      && instr_i[2:0] == 3'h0 |-> exec)
      else $error("an opcode tail was refused");

   AST_REPEAT_COUNT: assert property ( // [RQ8]
      @(posedge clk_i) disable iff (reset_i)
      exec [*2] |=> exec_cnt_q == 16'($past(exec_cnt_q, 2) + 16'h0002))
      else $error("repeat pass not counted once each");

   AST_WRAP: assert property ( // [RQ9]
      @(posedge clk_i) disable iff (reset_i)
      exec && !circ_en && plain_sum < dst_val |=>
      regs_q[$past(dst_idx)] == $past(plain_sum) && !illegal_o)
      else $error("sum did not wrap at 16 bits");

   COV_RR: cover property (@(posedge clk_i) disable iff (reset_i)
      exec && op == ARA_OP_REG);
   COV_CIRC: cover property (@(posedge clk_i) disable iff (reset_i)
      exec && circ_fits && legacy);
   COV_REPEAT: cover property (@(posedge clk_i) disable iff (reset_i)
      exec [*3]);

endmodule

// File: testbench/ara_dec_model.sv
/*
 * Model of the instruction decoder and repeat control that feed the
 * adder. Assumes the bench pulses go_i for one cycle per request.
 */
`timescale 1ns/1ns
module ara_dec_model (
   // Clock, reset and request
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic go_i,
   input wire logic [23:0] word_i,
   input wire logic [3:0] reps_i,
   // Instruction port
   output logic instr_valid_o,
   output logic [23:0] instr_o
);
   logic [3:0] cnt_q;
   logic [23:0] word_q;
   // Same word re-presented once per repeat iteration
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cnt_q <= 4'h0;
         word_q <= 24'h000000;
      end else if (go_i) begin
         cnt_q <= reps_i;
         word_q <= word_i;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end
   // Idle word inverted so a stale word never passes as a fresh one
   assign instr_valid_o = (cnt_q != 4'h0);
   assign instr_o = instr_valid_o ? word_q : ~word_q;
endmodule

// File: testbench/addr_reg_add_unit_tb.sv
/*
 * Self-checking bench of the address-register adder.
 * Assumes the decoder model in its own file and the design package.
 */
`timescale 1ns/1ns
module addr_reg_add_unit_tb;
   import ara_pkg::*;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [5:0] addr_i = 6'h00;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [15:0] rdata_o;
   logic instr_valid_i;
   logic [23:0] instr_i;
   logic done_o, illegal_o, dmem_req_o;
   logic go = 1'b0;
   logic [23:0] word = 24'h000000;
   logic [3:0] reps = 4'h0;
   int failures = 0;
   int n_tests = 0;
   int n_done = 0;
   int n_ill = 0;
   int cyc = 0;
   int i0;

   always #20 clk_i = ~clk_i;

   ara_unit uut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .instr_valid_i(instr_valid_i), .instr_i(instr_i),
      .done_o(done_o), .illegal_o(illegal_o), .dmem_req_o(dmem_req_o));
   ara_dec_model dec (.clk_i(clk_i), .reset_i(reset_i), .go_i(go),
      .word_i(word), .reps_i(reps), .instr_valid_o(instr_valid_i),
      .instr_o(instr_i));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Pulse counters, data-memory watch and hang limit
   always @(posedge clk_i) begin
      cyc++;
      if (done_o === 1'b1) n_done++;
      if (illegal_o === 1'b1) n_ill++;
      if (!reset_i) check({15'h0000, dmem_req_o}, 16'h0000);
      if (cyc > 3000) begin
         failures++;
         summarize;
      end
   end

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 check(rdata_o, exp);
   endtask

   // Issue a word n times and count completions; bounded wait
   task automatic ex(input logic [23:0] w, input logic [3:0] n,
                     input logic [15:0] dexp);
      int d0;
      int k;
      d0 = n_done;
      k = 0;
      @(posedge clk_i);
      go <= 1'b1;
      word <= w;
      reps <= n;
      @(posedge clk_i);
      go <= 1'b0;
      #1;
      while (instr_valid_i === 1'b1 && k < 20) begin
         @(posedge clk_i);
         #1;
         k++;
      end
      @(posedge clk_i);
      #1 check(16'(n_done - d0), dexp);
   endtask

   function automatic logic [23:0] rr(input logic [3:0] s, d, t);
      return {ARA_OPC_LEAD, ARA_OPC_MID, 1'b0, s, 4'h0, d, t};
   endfunction

   function automatic logic [23:0] im(input logic [7:0] v,
                                      input logic [3:0] d, t);
      return {ARA_OPC_LEAD, ARA_OPC_MID, 1'b0, v, d, t};
   endfunction

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      rd(ARA_ADDR_ST2, ARA_RST_VAL);
      wr(6'h0f, 16'h1234);
      rd(6'h0f, 16'h0000);
      wr(6'h01, 16'h0100);
      wr(6'h08, 16'h8000);
      ex(rr(4'h8, 4'h1, ARA_TAIL_RR_A), 4'h1, 16'h1);
      rd(6'h01, 16'h8100);
      ex(rr(4'h8, 4'h1, ARA_TAIL_RR_B), 4'h1, 16'h1);
      rd(6'h01, 16'h0100);
      wr(6'h09, 16'hfffe);
      wr(6'h02, 16'h0005);
      ex(rr(4'h9, 4'h2, ARA_TAIL_RR_A), 4'h1, 16'h1);
      rd(6'h02, 16'h0003);
      ex(im(8'hff, 4'h9, ARA_TAIL_IMM_A), 4'h1, 16'h1);
      rd(6'h09, 16'h00fd);
      ex(im(8'h80, 4'h3, ARA_TAIL_IMM_B), 4'h1, 16'h1);
      rd(6'h03, 16'h0080);
      // Circular folding above and below the low-bank window
      wr(ARA_ADDR_ST2, 16'h0002);
      wr(ARA_ADDR_SIZE_LO, 16'h0010);
      wr(ARA_ADDR_START_LO, 16'h0100);
      wr(6'h01, 16'h010e);
      wr(6'h0a, 16'h0003);
      wr(6'h0b, 16'hfffd);
      ex(rr(4'ha, 4'h1, ARA_TAIL_RR_A), 4'h1, 16'h1);
      rd(6'h01, 16'h0101);
      ex(rr(4'hb, 4'h1, ARA_TAIL_RR_A), 4'h1, 16'h1);
      rd(6'h01, 16'h010e);
      // High-bank register: legacy mode must use the low bank
      wr(ARA_ADDR_SIZE_HI, 16'h0040);
      wr(ARA_ADDR_START_HI, 16'h0200);
      wr(6'h05, 16'h010e);
      // Translated legacy code sets the legacy bit before adding
      wr(ARA_ADDR_ST2, 16'h0120);
      rd(ARA_ADDR_ST2, 16'h0120);
      ex(rr(4'ha, 4'h5, ARA_TAIL_RR_A), 4'h1, 16'h1);
      rd(6'h05, 16'h0101);
      wr(ARA_ADDR_ST2, 16'h0020);
      wr(6'h05, 16'h020e);
      ex(rr(4'ha, 4'h5, ARA_TAIL_RR_A), 4'h1, 16'h1);
      rd(6'h05, 16'h0211);
      // Temp destination never folds, even with the matching bit set
      wr(ARA_ADDR_ST2, 16'h0001);
      ex(im(8'h20, 4'h8, ARA_TAIL_IMM_A), 4'h1, 16'h1);
      rd(6'h08, 16'h8020);
      // Repeat: four back-to-back executions
      wr(ARA_ADDR_ST2, 16'h0000);
      wr(ARA_ADDR_COUNT, 16'h0000);
      wr(6'h06, 16'h0000);
      ex(im(8'h05, 4'h6, ARA_TAIL_IMM_A), 4'h4, 16'h4);
      rd(6'h06, 16'h0014);
      rd(ARA_ADDR_COUNT, 16'h0004);
      // Bad register code and a foreign tail
      i0 = n_ill;
      ex(rr(4'h1, 4'hc, ARA_TAIL_RR_A), 4'h1, 16'h0);
      check(16'(n_ill - i0), 16'h0001);
      // Bad source code in register form is refused too
      i0 = n_ill;
      ex(rr(4'hd, 4'h6, ARA_TAIL_RR_B), 4'h1, 16'h0);
      check(16'(n_ill - i0), 16'h0001);
      ex(rr(4'h1, 4'h6, 4'h2), 4'h1, 16'h0);
      rd(6'h06, 16'h0014);
      summarize;
   end
endmodule
